// file: rtl/bus_memory_controller.sv
/*
 * System bus memory controller: fixed-priority arbiter, address decoder,
 * remap, misalignment detector, abort capture and region protection unit.
 * Assumes masters hold a request until granted and done; one system clock.
 */
// The register addresses and register access over Wishbone were decided locally.
// Behaviour
// [RULE_01] DMA master wins over processor always
// [RULE_02] Top nibble: internal 0, peripherals F
// [RULE_03] Fourteen middle regions abort
// [RULE_04] Eight more bits pick 1 MB area
// [RULE_05] Small memories mirror across their area
// [RULE_06] Unassigned internal area aborts
// [RULE_07] Area zero aliases ROM or SRAM
// [RULE_08] Writing one toggles remap; zero nothing
// [RULE_09] Abort goes to both masters
// [RULE_10] Capture full aborted address
// [RULE_11] Record size, type and causes
// [RULE_12] Source flag names last aborting master
// [RULE_13] Sticky per-master abort since status read
// [RULE_14] Protection disabled after reset
// [RULE_15] Sixteen programmable protection regions
// [RULE_16] Region size 1 KB to 4 MB
// [RULE_17] Peripheral space has own permission
// [RULE_18] Forbidden accesses abort as protection
// [RULE_19] Overlaps take strongest protection
// [RULE_20] Enabled: uncovered internal access aborts
// [RULE_21] Misaligned data accesses abort
// [RULE_22] Instruction fetches skip alignment check
// [RULE_23] Little-endian accesses only
// [RULE_24] Disabled unit raises no protection abort
// [RULE_25] New abort overwrites captured details
`timescale 1ns/1ns
module bus_memory_controller
	import memctl_pkg::*;
#(
	parameter int         regions_n = 16,
	parameter logic [7:0] ram_size_bits = 8'd17
)(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Processor master request.
	input  wire logic        cpu_req_i,
	input  wire logic [31:0] cpu_addr_i,
	input  wire logic [1:0]  cpu_size_i,
	input  wire logic [1:0]  cpu_type_i,
	input  wire logic        cpu_user_i,
	// DMA master request.
	input  wire logic        dma_req_i,
	input  wire logic [31:0] dma_addr_i,
	input  wire logic [1:0]  dma_size_i,
	input  wire logic        dma_write_i,
	// Granted access toward the memories.
	output logic             cpu_grant_o,
	output logic             dma_grant_o,
	output logic             abort_o,
	output logic             rom_sel_o,
	output logic             sram_sel_o,
	output logic             periph_sel_o,
	output logic [31:0]      mem_addr_o,
	output logic             mem_write_o,
	output logic [1:0]       mem_size_o,
	// Wishbone register port.
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o
);

	////////////////////////////////////////////////////////////////////////
	// Arbitration and request selection.

	logic        dma_win;
	logic        any_req;
	logic [31:0] a;
	logic [1:0]  sz;
	logic [1:0]  ty;
	logic        wr;
	logic        usr;

	// The DMA wins outright; no fairness, since it moves short bursts only.
	always_comb begin
		dma_win = dma_req_i;                             // RULE_01
		any_req = dma_req_i || cpu_req_i;
		a   = dma_win ? dma_addr_i : cpu_addr_i;
		sz  = dma_win ? dma_size_i : cpu_size_i;
		ty  = dma_win ? (dma_write_i ? type_write : type_read) : cpu_type_i;
		wr  = (ty == type_write);
		usr = dma_win ? 1'b0 : cpu_user_i;
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration state.

	logic                 remap_r;
	logic                 permission_field_en_r;
	logic [31:0]          region_r [regions_n];
	logic [31:0]          periph_r;
	logic [31:0]          abort_addr_r;
	logic [31:0]          status_r;

	////////////////////////////////////////////////////////////////////////
	// Address decoding.

	logic [7:0]  area;
	logic        undef_top;
	logic        undef_int;
	logic        is_int;
	logic        is_periph;
	logic        hit_rom;
	logic        hit_sram;
	logic [31:0] phys;

	// Area 0 aliases ROM before remap and SRAM after; both stay at home too.
	always_comb begin
		is_int    = (a[31:28] == internal_nibble);        // RULE_02
		is_periph = (a[31:28] == periph_nibble);          // RULE_02
		undef_top = !is_int && !is_periph;                // RULE_03
		area      = a[27:20];                             // RULE_04
		hit_rom   = is_int && (area == rom_area || (area == zero_area && !remap_r)); // RULE_07
		hit_sram  = is_int && (area == sram_area || (area == zero_area && remap_r)); // RULE_07
		undef_int = is_int && !hit_rom && !hit_sram;      // RULE_06
		// Only offset bits below the memory size reach it, so it mirrors.
		phys = a & ((32'h0000_0001 << ram_size_bits) - 32'h0000_0001); // RULE_05
	end

	////////////////////////////////////////////////////////////////////////
	// Misalignment and protection.

	logic misaligned;
	logic [regions_n-1:0] hit_v;
	logic [regions_n-1:0] deny_v;
	logic periph_deny;
	logic permission_field_fault;

	// Fetches are never checked; bytes are always aligned.
	always_comb
		misaligned = (ty != type_fetch) &&                 // RULE_22
			((sz == size_word && a[1:0] != 2'b00) ||
			 (sz == size_half && a[0]));                    // RULE_21

	genvar gi;
	generate
		for (gi = 0; gi < regions_n; gi++) begin : g_region
			region_check u_chk (                            // RULE_15 RULE_16
				.addr_i  (a),
				.cfg_i   (region_r[gi]),
				.whole_i (1'b0),
				.write_i (wr),
				.user_i  (usr),
				.hit_o   (hit_v[gi]),
				.deny_o  (deny_v[gi])
			);
		end
	endgenerate

	region_check u_periph (
		.addr_i  (a),
		.cfg_i   (periph_r),
		.whole_i (1'b1),
		.write_i (wr),
		.user_i  (usr),
		.hit_o   (),
		.deny_o  (periph_deny)                            // RULE_17
	);

	// Any denying hit region wins, so overlaps take the strictest rights.
	always_comb begin
		permission_field_fault = 1'b0;
		if (permission_field_en_r) begin                              // RULE_24
			if (is_int)
				permission_field_fault = ((hit_v & deny_v) != '0)      // RULE_19 RULE_18
					|| (hit_v == '0);                       // RULE_20
			else if (is_periph)
				permission_field_fault = periph_deny;                   // RULE_18
		end
	end

	logic undef_any;
	logic abort_now;

	always_comb begin
		undef_any = undef_top || undef_int;
		abort_now = any_req && (undef_any || misaligned || permission_field_fault);
	end

	////////////////////////////////////////////////////////////////////////
	// Bus outputs, registered one cycle after the request.

	// Aborted accesses are cancelled: no select reaches any memory.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_grant_o  <= 1'b0;
			dma_grant_o  <= 1'b0;
			abort_o      <= 1'b0;
			rom_sel_o    <= 1'b0;
			sram_sel_o   <= 1'b0;
			periph_sel_o <= 1'b0;
			mem_addr_o   <= zero_word;
			mem_write_o  <= 1'b0;
			mem_size_o   <= 2'b00;
		end else begin
			cpu_grant_o  <= cpu_req_i && !dma_win;          // RULE_01
			dma_grant_o  <= dma_win;
			abort_o      <= abort_now;                      // RULE_09
			rom_sel_o    <= any_req && !abort_now && hit_rom;
			sram_sel_o   <= any_req && !abort_now && hit_sram;
			periph_sel_o <= any_req && !abort_now && is_periph;
			// Byte lanes follow little-endian order; no swap path exists.
			mem_addr_o   <= is_periph ? a : phys;           // RULE_23
			mem_write_o  <= any_req && !abort_now && wr;
			mem_size_o   <= sz;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register port decode.

	logic       wb_hit;
	logic       wb_wr;
	logic       wb_rd;
	logic [3:0] ridx;
	logic       is_region;

	always_comb begin
		wb_hit    = cyc_i && stb_i && !ack_o;
		wb_wr     = wb_hit && we_i && sel_i[0];
		wb_rd     = wb_hit && !we_i;
		is_region = adr_i >= region_config_first && adr_i <= region_config_last
			&& adr_i[1:0] == 2'b00;
		ridx      = 4'(adr_i[5:2] - 4'h4);
	end

	// Ack one cycle after the strobe, then low for a cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= wb_hit;
	end

	// Remap toggles on a written one; a zero leaves it alone.
	always_ff @(posedge clk_i) begin
		if (rst_i)
			remap_r <= 1'b0;
		else if (wb_wr && adr_i == remap_control_off && dat_i[0])
			remap_r <= !remap_r;                          // RULE_08
	end

	// Protection unit comes up off and all regions cleared.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			permission_field_en_r <= 1'b0;                            // RULE_14
			periph_r  <= zero_word;
			for (int i = 0; i < regions_n; i++)
				region_r[i] <= zero_word;
		end else if (wb_wr) begin
			if (adr_i == permission_field_enable_off)
				permission_field_en_r <= dat_i[0];                    // RULE_14
			if (adr_i == periph_permission_field_off)
				periph_r <= {30'h0, dat_i[1:0]};          // RULE_17
			if (is_region)
				region_r[ridx] <= dat_i & 32'h003f_fcf3;  // RULE_15
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Abort capture.

	logic status_read;
	logic fresh_r;

	always_comb status_read = wb_rd && adr_i == abort_status_off;

	// A new abort overwrites details; an unread displaced report goes sticky.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			abort_addr_r <= zero_word;
			status_r     <= zero_word;
		end else begin
			if (abort_now) begin
				abort_addr_r <= a;                         // RULE_10 RULE_25
				status_r[undef_pos]          <= undef_any; // RULE_11
				status_r[misalign_pos]       <= misaligned;
				status_r[permission_field_pos]           <= permission_field_fault && !undef_any && !misaligned;
				status_r[size_lsb +: 2]      <= sz;
				status_r[type_lsb +: 2]      <= ty;
				status_r[cpu_src_pos]        <= !dma_win;  // RULE_12
				status_r[dma_src_pos]        <= dma_win;
			end
			// Set beats the clearing read so no abort is lost.
			if (abort_now && fresh_r && status_r[cpu_src_pos])
				status_r[cpu_sav_pos] <= 1'b1;             // RULE_13
			else if (status_read)
				status_r[cpu_sav_pos] <= 1'b0;
			if (abort_now && fresh_r && status_r[dma_src_pos])
				status_r[dma_sav_pos] <= 1'b1;             // RULE_13
			else if (status_read)
				status_r[dma_sav_pos] <= 1'b0;
		end
		fresh_r <= !rst_i && (abort_now || (fresh_r && !status_read)); // RULE_13
	end

	// Read data is registered with the ack; unmapped offsets read zero.
	always_ff @(posedge clk_i) begin
		if (rst_i)
			dat_o <= zero_word;
		else if (wb_rd) begin
			if (adr_i == abort_status_off)
				dat_o <= status_r;
			else if (adr_i == abort_address_off)
				dat_o <= abort_addr_r;
			else if (is_region)
				dat_o <= region_r[ridx];
			else if (adr_i == periph_permission_field_off)
				dat_o <= periph_r;
			else if (adr_i == permission_field_enable_off)
				dat_o <= {31'h0, permission_field_en_r};
			else
				dat_o <= zero_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	dma_priority_a: assert property (@(posedge clk_i) disable iff (rst_i)
		dma_req_i && cpu_req_i |=> dma_grant_o && !cpu_grant_o) // RULE_01
		else $error("processor granted over dma");

	undef_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
		any_req && undef_top |=> abort_o && !rom_sel_o && !sram_sel_o) // RULE_03
		else $error("undefined region not aborted");

	area_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		any_req && is_int && area == zero_area && !undef_any && !misaligned
		&& !permission_field_fault |=> (rom_sel_o == !$past(remap_r))) // RULE_07
		else $error("area zero alias wrong");

	remap_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_wr && adr_i == remap_control_off && dat_i[0] |=> remap_r != $past(remap_r)) // RULE_08
		else $error("remap did not toggle");

	abort_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		abort_now |=> abort_addr_r == $past(a)) // RULE_10
		else $error("abort address not captured");

	misalign_a: assert property (@(posedge clk_i) disable iff (rst_i)
		any_req && ty != type_fetch && sz == size_word && a[1:0] != 2'b00
		|=> abort_o ##0 status_r[misalign_pos]) // RULE_21
		else $error("misaligned word not aborted");

	fetch_exempt_a: assert property (@(posedge clk_i) disable iff (rst_i)
		any_req && ty == type_fetch && !undef_any && !permission_field_fault |=> !abort_o) // RULE_22
		else $error("fetch aborted for alignment");

	permission_field_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		any_req && !permission_field_en_r && !undef_any && !misaligned |=> !abort_o) // RULE_24
		else $error("protection fault while disabled");

	cov_remap_c: cover property (@(posedge clk_i) remap_r ##1 !remap_r);
	cov_permission_field_c:  cover property (@(posedge clk_i) abort_now && permission_field_fault);
	cov_both_c:  cover property (@(posedge clk_i) dma_req_i && cpu_req_i ##1 abort_o);

endmodule // bus_memory_controller

// file: rtl/memctl_pkg.sv
/*
 * Constants shared by the system bus memory controller: register offsets,
 * field positions, decoder codes, access size and type encodings.
 * Assumes a 32-bit Wishbone register port with word-aligned byte addresses.
 */
package memctl_pkg;

	// Register byte offsets on the configuration port.
	localparam logic [7:0] remap_control_off    = 8'h00;
	localparam logic [7:0] abort_status_off     = 8'h04;
	localparam logic [7:0] abort_address_off    = 8'h08;
	localparam logic [7:0] region_config_first  = 8'h10;
	localparam logic [7:0] region_config_last   = 8'h4c;
	localparam logic [7:0] periph_permission_field_off      = 8'h50;
	localparam logic [7:0] permission_field_enable_off      = 8'h54;

	// Abort status field positions.
	localparam int undef_pos    = 0;
	localparam int misalign_pos = 1;
	localparam int permission_field_pos     = 2;
	localparam int size_lsb     = 8;
	localparam int type_lsb     = 10;
	localparam int cpu_src_pos  = 16;
	localparam int dma_src_pos  = 17;
	localparam int cpu_sav_pos  = 24;
	localparam int dma_sav_pos  = 25;

	// Region configuration field positions.
	localparam int reg_size_lsb = 4;
	localparam int reg_base_lsb = 10;

	// Decoder codes for the top nibble and memory areas.
	localparam logic [3:0] internal_nibble = 4'h0;
	localparam logic [3:0] periph_nibble   = 4'hf;
	localparam logic [7:0] rom_area        = 8'h01; // Byte address 0x0010_0000.
	localparam logic [7:0] sram_area       = 8'h02; // Byte address 0x0020_0000.
	localparam logic [7:0] zero_area       = 8'h00;

	// Reset values.
	localparam logic [31:0] zero_word = 32'h0000_0000;

	// Region size: code 0 is 1 KB, code 12 is 4 MB; larger codes clip to 4 MB.
	localparam logic [4:0] size_shift_min = 5'd10;
	localparam logic [3:0] size_code_max  = 4'hc;

	typedef enum logic [1:0] {
		size_byte = 2'b00,
		size_half = 2'b01,
		size_word = 2'b10
	} acc_size_t;

	typedef enum logic [1:0] {
		type_read  = 2'b00,
		type_write = 2'b01,
		type_fetch = 2'b10
	} acc_type_t;

endpackage

// file: rtl/region_check.sv
/*
 * Permission check for one protection region or the peripheral space.
 * Assumes the region base is aligned to its size; registered in the caller.
 */
`timescale 1ns/1ns
module region_check
	import memctl_pkg::*;
(
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] cfg_i,
	input  wire logic        whole_i,
	input  wire logic        write_i,
	input  wire logic        user_i,
	output logic             hit_o,
	output logic             deny_o
);

	logic [4:0]  shift;
	logic [31:0] mask;
	logic [1:0]  perm;

	// Size code s covers 2**(s+10) bytes; codes above 4 MB clip, never wrap.
	always_comb begin
		shift = 5'(cfg_i[reg_size_lsb +: 4]);
		if (shift > 5'(size_code_max))
			shift = 5'(size_code_max);
		shift = shift + size_shift_min;
		mask = ~((32'h0000_0001 << shift) - 32'h0000_0001);
		hit_o = whole_i || ((addr_i & mask & 32'h00ff_ffff) ==
			(cfg_i & mask & 32'h003f_fc00));
		perm = cfg_i[1:0];
		// Two-bit permission: none, privileged only, user read, open.
		deny_o = (perm == 2'b00) || (user_i && perm == 2'b01)
			|| (user_i && write_i && perm == 2'b10);
	end

endmodule // region_check

// file: verif/bus_masters_model.sv
/*
 * Processor and DMA master model on the request side of the controller.
 * Assumes the bench calls issue just after a rising edge of clk_i.
 */
`timescale 1ns/1ns
module bus_masters_model (
	input  wire logic        clk_i,
	output logic             cpu_req_o,
	output logic [31:0]      cpu_addr_o,
	output logic [1:0]       cpu_size_o,
	output logic [1:0]       cpu_type_o,
	output logic             cpu_user_o,
	output logic             dma_req_o,
	output logic [31:0]      dma_addr_o,
	output logic [1:0]       dma_size_o,
	output logic             dma_write_o
);
	// Both masters stay idle from time zero.
	initial begin
		cpu_req_o = 1'b0;
		cpu_addr_o = 32'h0000_0000;
		cpu_size_o = 2'h0;
		cpu_type_o = 2'h0;
		cpu_user_o = 1'b0;
		dma_req_o = 1'b0;
		dma_addr_o = 32'h0000_0000;
		dma_size_o = 2'h0;
		dma_write_o = 1'b0;
	end
	// One request cycle, little-endian lanes only; the DMA writes on a write type.
	// Released lines carry the inverted address; with the request dropped it reaches no select.
	task automatic issue(input logic c, input logic d, input logic [31:0] a,
		input logic [1:0] s, input logic [1:0] t, input logic u);
		cpu_req_o <= c;
		dma_req_o <= d;
		cpu_addr_o <= a;
		dma_addr_o <= a;
		cpu_size_o <= s;
		dma_size_o <= s;
		cpu_type_o <= t;
		cpu_user_o <= u;
		dma_write_o <= (t == 2'h1);
		@(posedge clk_i);
		cpu_req_o <= 1'b0;
		dma_req_o <= 1'b0;
		cpu_addr_o <= ~a;
		dma_addr_o <= ~a;
	endtask
endmodule // bus_masters_model

// file: verif/test_bus_memory_controller.sv
/*
 * Self-checking bench for the memory controller: decode, remap, arbiter,
 * alignment, abort status and protection. Assumes the master model file.
 */
`timescale 1ns/1ns
module test_bus_memory_controller
	import memctl_pkg::*;
;
	logic        clk_i = 1'b0, rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000, dat_o, mem_addr_o, q, cpu_addr, dma_addr;
	logic        ack_o, abort_o, cpu_grant_o, dma_grant_o, rom_sel_o, sram_sel_o;
	logic        periph_sel_o, mem_write_o, cpu_req, cpu_user, dma_req, dma_write;
	logic [1:0]  mem_size_o, cpu_size, cpu_type, dma_size;
	int          n_errors = 0, total_checks = 0;

	bus_masters_model u_masters (.clk_i(clk_i), .cpu_req_o(cpu_req),
		.cpu_addr_o(cpu_addr), .cpu_size_o(cpu_size), .cpu_type_o(cpu_type),
		.cpu_user_o(cpu_user), .dma_req_o(dma_req), .dma_addr_o(dma_addr),
		.dma_size_o(dma_size), .dma_write_o(dma_write));
	bus_memory_controller #(.regions_n(16), .ram_size_bits(8'd17)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .cpu_req_i(cpu_req), .cpu_addr_i(cpu_addr),
		.cpu_size_i(cpu_size), .cpu_type_i(cpu_type), .cpu_user_i(cpu_user),
		.dma_req_i(dma_req), .dma_addr_i(dma_addr), .dma_size_i(dma_size),
		.dma_write_i(dma_write), .cpu_grant_o(cpu_grant_o), .dma_grant_o(dma_grant_o),
		.abort_o(abort_o), .rom_sel_o(rom_sel_o), .sram_sel_o(sram_sel_o),
		.periph_sel_o(periph_sel_o), .mem_addr_o(mem_addr_o),
		.mem_write_o(mem_write_o), .mem_size_o(mem_size_o), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat),
		.dat_o(dat_o), .ack_o(ack_o));

	// Free-running 10 MHz system clock.
	always #50 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////
	// Shared helpers.
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// Classic Wishbone cycle held until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		wb(1'b0, a, 32'h0000_0000);
		chk(q, x);
	endtask
	// Expected e is {abort, periph, sram, rom} one edge after the request.
	task automatic acc(input logic c, input logic d, input logic [31:0] a,
		input logic [1:0] s, input logic [1:0] t, input logic u, input logic [3:0] e);
		@(posedge clk_i);
		u_masters.issue(c, d, a, s, t, u);
		#1 chk({abort_o, periph_sel_o, sram_sel_o, rom_sel_o}, e);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_reset_regs;
		rd(abort_status_off, zero_word);
		rd(abort_address_off, zero_word);
		rd(region_config_last, zero_word);
		rd(permission_field_enable_off, zero_word);
		rd(8'h0c, zero_word);
	endtask
	task automatic t_decode;
		acc(1, 0, 32'h1000_0000, size_word, type_read, 0, 4'h8);
		acc(1, 0, 32'he000_0000, size_word, type_read, 0, 4'h8);
		acc(1, 0, 32'hf000_0000, size_word, type_read, 0, 4'h4);
		acc(1, 0, 32'h0030_0000, size_word, type_read, 0, 4'h8);
		rd(abort_address_off, 32'h0030_0000);
		acc(1, 0, 32'h0012_0004, size_word, type_read, 0, 4'h1);
		chk(mem_addr_o, 32'h0000_0004);
	endtask
	task automatic t_remap;
		wb(1'b1, remap_control_off, 32'h0000_0000);
		acc(1, 0, 32'h0000_0000, size_word, type_read, 0, 4'h1);
		wb(1'b1, remap_control_off, 32'h0000_0001);
		acc(1, 0, 32'h0000_0010, size_word, type_read, 0, 4'h2);
		acc(1, 0, 32'h0020_0000, size_word, type_read, 0, 4'h2);
		acc(1, 0, 32'h0010_0000, size_word, type_read, 0, 4'h1);
		wb(1'b1, remap_control_off, 32'h0000_0001);
		acc(1, 0, 32'h0000_0000, size_word, type_read, 0, 4'h1);
	endtask
	task automatic t_arbiter;
		acc(1, 1, 32'h0010_0000, size_word, type_read, 0, 4'h1);
		chk({cpu_grant_o, dma_grant_o}, 2'b01);
		acc(1, 0, 32'h0010_0000, size_word, type_read, 0, 4'h1);
		chk({cpu_grant_o, dma_grant_o}, 2'b10);
	endtask
	task automatic t_align;
		wb(1'b0, abort_status_off, 32'h0000_0000);
		acc(1, 0, 32'h0010_0002, size_word, type_read, 0, 4'h8);
		rd(abort_status_off, 32'h0001_0202);
		acc(1, 0, 32'h0010_0002, size_word, type_fetch, 0, 4'h1);
		acc(0, 1, 32'h0010_0001, size_half, type_write, 0, 4'h8);
		acc(0, 1, 32'h0010_0003, size_word, type_write, 0, 4'h8);
		rd(abort_status_off, 32'h0202_0602);
		rd(abort_address_off, 32'h0010_0003);
		rd(abort_status_off, 32'h0002_0602);
	endtask
	task automatic t_protect;
		wb(1'b1, region_config_first, 32'h0020_0002);
		wb(1'b1, 8'h14, 32'h0020_0001);
		rd(region_config_first, 32'h0020_0002);
		wb(1'b1, periph_permission_field_off, 32'h0000_0001);
		acc(1, 0, 32'h0020_0400, size_word, type_read, 1, 4'h2);
		wb(1'b1, permission_field_enable_off, 32'h0000_0001);
		acc(1, 0, 32'h0020_0000, size_word, type_write, 0, 4'h2);
		acc(1, 0, 32'h0020_0000, size_word, type_read, 1, 4'h8);
		rd(abort_status_off, 32'h0001_0204);
		acc(1, 0, 32'h0020_0400, size_word, type_read, 0, 4'h8);
		acc(1, 0, 32'h0020_03fc, size_word, type_read, 0, 4'h2);
		wb(1'b1, 8'h18, 32'h0000_00c3);
		acc(1, 0, 32'h0010_0000, size_word, type_read, 1, 4'h1);
		acc(1, 0, 32'h0020_0000, size_word, type_read, 1, 4'h8);
		acc(1, 0, 32'hf000_0000, size_word, type_read, 1, 4'h8);
		acc(0, 1, 32'hf000_0000, size_word, type_write, 0, 4'h4);
		chk({mem_write_o, mem_size_o}, 32'h0000_0006);
		wb(1'b1, permission_field_enable_off, 32'h0000_0000);
		acc(1, 0, 32'h0020_0400, size_word, type_read, 1, 4'h2);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence: ten reset cycles, then every scenario in turn.
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset_regs();
		t_decode();
		t_remap();
		t_arbiter();
		t_align();
		t_protect();
		report_and_stop();
	end
	// Watchdog well beyond the roughly 130 cycles the scenarios need.
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
endmodule // test_bus_memory_controller
